// ===== core/sacl_pkg.sv
package sacl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PRESET_FIRST  = 8'h12;
  localparam logic [7:0] ADDR_PRESET_SECOND = 8'h14;
  localparam logic [7:0] ADDR_POWER_LEVEL   = 8'h29;
  localparam logic [7:0] ADDR_LOADER_STATUS = 8'h30;
  localparam logic [7:0] REG_CLEAR          = 8'h00;
  localparam logic [7:0] REG_ALL_PORTS      = 8'hff;
  localparam logic [7:0] LEVEL_LOW          = 8'h00;
  localparam logic [7:0] LEVEL_HIGH         = 8'h33;

  // ----------------------------------------------------------------
  // strap classes from the resistance front end
  // ----------------------------------------------------------------
  localparam logic [1:0] CLASS_OPEN     = 2'h0;
  localparam logic [1:0] CLASS_124K     = 2'h1;
  localparam logic [1:0] CLASS_62K      = 2'h2;

  // ----------------------------------------------------------------
  // timing and bus
  // ----------------------------------------------------------------
  localparam int         CLOCK_MHZ       = 25;
  localparam int         STRAP_SETTLE_US = 100;
  localparam int         STRAP_SETTLE_CYC = STRAP_SETTLE_US * CLOCK_MHZ;
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h20;
  localparam int         PORTS           = 8;

  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
    logic [7:0] level;
    logic       autonomous;
  } sacl_preset_t;

endpackage : sacl_pkg

// ===== core/sacl_strap.sv
`timescale 1ns/10ps
`default_nettype none
module sacl_strap
#(
  parameter int SETTLE_CYC = sacl_pkg::STRAP_SETTLE_CYC
) (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic [1:0]        strap_class_raw,
  output sacl_pkg::sacl_preset_t preset,
  output logic                   load,
  output logic                   done,
  output logic [1:0]             strap_class
);
  import sacl_pkg::*;
  // ----------------------------------------------------------------
  // class synchroniser and settle counter
  // ----------------------------------------------------------------
  logic [1:0]  class_meta;
  logic [1:0]  class_sync;
  logic [15:0] settle_cnt;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      class_meta <= CLASS_OPEN;
      class_sync <= CLASS_OPEN;
    end else begin
      class_meta <= strap_class_raw;
      class_sync <= class_meta;
    end
  end

  // only the power-on reset restarts this; later strap moves are ignored
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt  <= 16'h0000;
      done        <= 1'b0;
      load        <= 1'b0;
      strap_class <= CLASS_OPEN;
    end else begin
      load <= 1'b0;
      if (!done) begin
        if (settle_cnt == 16'(SETTLE_CYC - 1)) begin
          done        <= 1'b1;
          load        <= 1'b1;
          strap_class <= class_sync;
        end else begin
          settle_cnt <= settle_cnt + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // class decode; an unknown class is taken as open, the safe choice
  // ----------------------------------------------------------------
  always_comb begin
    preset = '{REG_CLEAR, REG_CLEAR, LEVEL_LOW, 1'b0};
    case (strap_class)
      CLASS_124K: preset = '{REG_ALL_PORTS, REG_ALL_PORTS, LEVEL_LOW, 1'b1};
      CLASS_62K:  preset = '{REG_ALL_PORTS, REG_ALL_PORTS, LEVEL_HIGH, 1'b1};
      default:    preset = '{REG_CLEAR, REG_CLEAR, LEVEL_LOW, 1'b0};
    endcase
  end

  a_strap_frozen: assert property (@(posedge clock) disable iff (!arst_n)
    done |=> $stable(strap_class) && done)
    else $error("strap class moved after latch");

  a_strap_once: assert property (@(posedge clock) disable iff (!arst_n)
    load |-> $past(!done) ##1 !load [*4])
    else $error("strap latched more than once");

endmodule : sacl_strap
`default_nettype wire

// ===== core/sacl_loader.sv
`timescale 1ns/10ps
`default_nettype none
module sacl_loader
#(
  parameter logic [6:0] BUS_ADDR   = sacl_pkg::BUS_ADDR_DEFAULT,
  parameter int         SETTLE_CYC = sacl_pkg::STRAP_SETTLE_CYC
) (
  input  wire logic                  CLOCK,
  input  wire logic                  ARST_N,
  input  wire logic                  HW_RESET_N,
  input  wire logic [1:0]            STRAP_CLASS,
  input  wire logic                  SCL_IN,
  input  wire logic                  SDA_IN,
  output logic                       SDA_OUT,
  output logic                       SDA_OE,
  output logic                       AUTO_MODE,
  output logic                       CONFIG_DONE,
  output logic [sacl_pkg::PORTS-1:0] PORT_ACTIVE,
  output logic [sacl_pkg::PORTS-1:0] PORT_HIGH
);
  import sacl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b011,
    ST_TX   = 3'b010,
    ST_RACK = 3'b110
  } sacl_state_t;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] hw_meta, hw_sync;
  logic [2:0] scl_s, sda_s;
  logic       hw_reset;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      hw_meta <= 2'h3;
      hw_sync <= 2'h3;
      scl_s   <= 3'h7;
      sda_s   <= 3'h7;
    end else begin
      hw_meta <= {hw_meta[0], HW_RESET_N};
      hw_sync <= {hw_sync[0], hw_meta[1]};
      scl_s   <= {scl_s[1:0], SCL_IN};
      sda_s   <= {sda_s[1:0], SDA_IN};
    end
  end

  // stage 0 is the metastable flop; only stage 1 and 2 feed logic
  assign hw_reset = !hw_sync[1];
  wire scl_rise = scl_s[1] && !scl_s[2];
  wire scl_fall = !scl_s[1] && scl_s[2];
  wire bus_start = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
  wire bus_stop  = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];

  // ----------------------------------------------------------------
  // strap loader
  // ----------------------------------------------------------------
  sacl_preset_t preset;
  logic         preset_load;
  logic         strap_done;
  logic [1:0]   strap_class;

  sacl_strap #(
    .SETTLE_CYC      (SETTLE_CYC)
  ) u_strap (
    .clock           (CLOCK),
    .arst_n          (ARST_N),
    .strap_class_raw (STRAP_CLASS),
    .preset          (preset),
    .load            (preset_load),
    .done            (strap_done),
    .strap_class     (strap_class)
  );

  // ----------------------------------------------------------------
  // serial register port
  // ----------------------------------------------------------------
  sacl_state_t state;
  logic [7:0]  rx_sh, tx_sh, ptr;
  logic [3:0]  bit_cnt;
  logic [1:0]  byte_idx;
  logic        read_op, ack_drive;
  logic        wr_en;
  logic [7:0]  wr_addr, wr_data;
  logic [7:0]  reg_first, reg_second, reg_level;
  logic        auto_mode;
  logic [7:0]  rd_data;

  always_comb begin
    case (ptr)
      ADDR_PRESET_FIRST:  rd_data = reg_first;
      ADDR_PRESET_SECOND: rd_data = reg_second;
      ADDR_POWER_LEVEL:   rd_data = reg_level;
      ADDR_LOADER_STATUS: rd_data = {4'h0, strap_class, auto_mode, strap_done};
      default:            rd_data = REG_CLEAR;
    endcase
  end

  // host access is refused until the strap is latched
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state     <= ST_IDLE;
      rx_sh     <= 8'h00;
      tx_sh     <= 8'h00;
      ptr       <= 8'h00;
      bit_cnt   <= 4'h0;
      byte_idx  <= 2'h0;
      read_op   <= 1'b0;
      ack_drive <= 1'b0;
      wr_en     <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (bus_stop || !strap_done || hw_reset) begin
        state     <= ST_IDLE;
        ack_drive <= 1'b0;
      end else if (bus_start) begin
        state     <= ST_RX;
        bit_cnt   <= 4'h0;
        byte_idx  <= 2'h0;
        ack_drive <= 1'b0;
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              rx_sh   <= {rx_sh[6:0], sda_s[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              state <= ST_ACK;
              if (byte_idx == 2'h0) begin
                read_op   <= rx_sh[0];
                ack_drive <= rx_sh[7:1] == BUS_ADDR;
                if (rx_sh[7:1] != BUS_ADDR) begin
                  state <= ST_IDLE;
                end
                byte_idx <= 2'h1;
              end else if (byte_idx == 2'h1) begin
                ptr       <= rx_sh;
                ack_drive <= 1'b1;
                byte_idx  <= 2'h2;
              end else begin
                wr_en     <= 1'b1;
                wr_addr   <= ptr;
                wr_data   <= rx_sh;
                ptr       <= ptr + 8'h01;
                ack_drive <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (read_op) begin
                state     <= ST_TX;
                tx_sh     <= rd_data;
                ack_drive <= !rd_data[7];
              end else begin
                state     <= ST_RX;
                ack_drive <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                state     <= ST_RACK;
                ack_drive <= 1'b0;
                ptr       <= ptr + 8'h01;
              end else begin
                tx_sh     <= {tx_sh[6:0], 1'b0};
                ack_drive <= !tx_sh[6];
                bit_cnt   <= bit_cnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise && sda_s[1]) begin
              state <= ST_IDLE;
            end else if (scl_fall) begin
              state     <= ST_TX;
              bit_cnt   <= 4'h0;
              tx_sh     <= rd_data;
              ack_drive <= !rd_data[7];
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // preset registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      reg_first  <= REG_CLEAR;
      reg_second <= REG_CLEAR;
      reg_level  <= REG_CLEAR;
      auto_mode  <= 1'b0;
    end else if (hw_reset) begin
      reg_first  <= REG_CLEAR;
      reg_second <= REG_CLEAR;
      reg_level  <= REG_CLEAR;
      auto_mode  <= 1'b0;
    end else if (preset_load) begin
      reg_first  <= preset.first;
      reg_second <= preset.second;
      reg_level  <= preset.level;
      auto_mode  <= preset.autonomous;
    end else if (wr_en) begin
      if (wr_addr == ADDR_PRESET_FIRST) begin
        reg_first <= wr_data;
      end
      if (wr_addr == ADDR_PRESET_SECOND) begin
        reg_second <= wr_data;
      end
      if (wr_addr == ADDR_POWER_LEVEL) begin
        reg_level <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // port outputs
  // ----------------------------------------------------------------
  wire common_high = reg_level != LEVEL_LOW;

  for (genvar i = 0; i < PORTS; i++) begin : g_port
    always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
        PORT_ACTIVE[i] <= 1'b0;
        PORT_HIGH[i]   <= 1'b0;
      end else begin
        PORT_ACTIVE[i] <= strap_done && !hw_reset && reg_first[i] && reg_second[i];
        PORT_HIGH[i]   <= auto_mode ? common_high : reg_level[i];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      SDA_OUT     <= 1'b0;
      SDA_OE      <= 1'b0;
      AUTO_MODE   <= 1'b0;
      CONFIG_DONE <= 1'b0;
    end else begin
      SDA_OUT     <= 1'b0;
      SDA_OE      <= ack_drive && (state == ST_ACK || state == ST_TX);
      AUTO_MODE   <= auto_mode;
      CONFIG_DONE <= strap_done;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_no_port_early: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !strap_done |=> PORT_ACTIVE == '0)
    else $error("port active before strap latch");

  a_preset_values: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    preset_load && !hw_reset && strap_class == CLASS_62K |=>
      reg_first == REG_ALL_PORTS && reg_second == REG_ALL_PORTS && reg_level == LEVEL_HIGH)
    else $error("62k preset not loaded");

  a_auto_uniform: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    auto_mode |=> PORT_HIGH == '0 || PORT_HIGH == '1)
    else $error("ports differ in autonomous level");

  a_auto_runs: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    preset_load && !hw_reset && preset.autonomous |=> ##1 PORT_ACTIVE == '1)
    else $error("autonomous ports did not start");

  a_hw_reset_off: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    hw_reset |=> reg_first == REG_CLEAR && PORT_ACTIVE == '0 && !auto_mode)
    else $error("hardware reset left a port on");

  a_host_override: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    wr_en && !hw_reset && !preset_load && wr_addr == ADDR_POWER_LEVEL |=>
      reg_level == $past(wr_data))
    else $error("host write lost");

  a_no_access_early: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !strap_done |-> !wr_en && state == ST_IDLE)
    else $error("host access before latch");

endmodule : sacl_loader
`default_nettype wire

// ===== testbench/sacl_host.sv
`timescale 1ns/10ps
`default_nettype none
module sacl_host
(
  input  wire logic clock,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl,
  output logic      sda
);
  import sacl_pkg::*;
  logic sda_drv;

  // released line floats high through the pull-up, never keeps a stale value
  assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);

  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  // ----------------------------------------------------------------
  // bus conditions, every phase at least 2 system clocks
  // ----------------------------------------------------------------
  task automatic start_cond();
    sda_drv <= 1'b1;
    wt(6);
    scl <= 1'b1;
    wt(8);
    sda_drv <= 1'b0;
    wt(8);
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    wt(2);
    sda_drv <= 1'b0;
    wt(6);
    scl <= 1'b1;
    wt(8);
    sda_drv <= 1'b1;
    wt(8);
  endtask : stop_cond

  // data moves only while scl is low; sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_drv <= b;
    wt(6);
    scl <= 1'b1;
    wt(4);
    @(negedge clock);
    r = sda;
    wt(4);
    scl <= 1'b0;
  endtask : bit_io

  // ninth bit always released: ack from device on writes, nack on reads
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(1'b1, ack);
  endtask : byte_io

  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    start_cond();
    byte_io({BUS_ADDR_DEFAULT, 1'b0}, r, a0);
    byte_io(ptr, r, a1);
    byte_io(d, r, a2);
    stop_cond();
    nak = a0 | a1 | a2;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start_cond();
    byte_io({BUS_ADDR_DEFAULT, 1'b0}, r, a0);
    byte_io(ptr, r, a1);
    start_cond();
    byte_io({BUS_ADDR_DEFAULT, 1'b1}, r, a2);
    byte_io(8'hff, d, a3);
    stop_cond();
    nak = a0 | a1 | a2;
  endtask : read_reg
endmodule : sacl_host
`default_nettype wire

// ===== testbench/tb_strap_autonomous_config_loader.sv
`timescale 1ns/10ps
`default_nettype none
module tb_strap_autonomous_config_loader;
  import sacl_pkg::*;
  logic             clock;
  logic             arst_n;
  logic             hw_reset_n;
  logic [1:0]       strap_class;
  logic             scl;
  logic             sda;
  logic             sda_out;
  logic             sda_oe;
  logic             auto_mode;
  logic             config_done;
  logic [PORTS-1:0] port_active;
  logic [PORTS-1:0] port_high;
  logic [7:0]       rd;
  logic             nak;
  int               errors;
  int               checks;

  // short settle count keeps the run brief
  sacl_loader #(.SETTLE_CYC(16)) dut (
    .CLOCK(clock), .ARST_N(arst_n), .HW_RESET_N(hw_reset_n),
    .STRAP_CLASS(strap_class), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .AUTO_MODE(auto_mode),
    .CONFIG_DONE(config_done), .PORT_ACTIVE(port_active), .PORT_HIGH(port_high));

  sacl_host host (
    .clock(clock), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // compares on the falling edge where outputs are settled
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    @(negedge clock);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
    @(posedge clock);
  endtask : chk

  task automatic rd_chk(input string what, input logic [7:0] ptr, input logic [7:0] exp);
    host.read_reg(ptr, rd, nak);
    chk("ack", 8'h00, {7'h00, nak});
    chk(what, exp, rd);
  endtask : rd_chk

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    host.write_reg(ptr, d, nak);
    chk("ack", 8'h00, {7'h00, nak});
  endtask : wr

  task automatic power_up(input logic [1:0] cls);
    arst_n      <= 1'b0;
    strap_class <= cls;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    chk("done early", 8'h00, {7'h00, config_done});
    chk("ports early", 8'h00, port_active);
    for (int i = 0; i < 200 && config_done !== 1'b1; i++) @(posedge clock);
    chk("done", 8'h01, {7'h00, config_done});
  endtask : power_up

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_strap(input logic [1:0] cls, input logic [7:0] e1, input logic [7:0] e2,
                         input logic [7:0] e3, input logic ea, input logic [7:0] eh);
    power_up(cls);
    chk("auto", {7'h00, ea}, {7'h00, auto_mode});
    chk("ports", e1 & e2, port_active);
    chk("level", eh, port_high);
    rd_chk("first", ADDR_PRESET_FIRST, e1);
    rd_chk("second", ADDR_PRESET_SECOND, e2);
    rd_chk("power", ADDR_POWER_LEVEL, e3);
    rd_chk("status", ADDR_LOADER_STATUS, {4'h0, cls, ea, 1'b1});
  endtask : t_strap

  task automatic t_latch();
    strap_class <= CLASS_OPEN;
    repeat (50) @(posedge clock);
    chk("auto kept", 8'h01, {7'h00, auto_mode});
    chk("ports kept", 8'hff, port_active);
    rd_chk("power kept", ADDR_POWER_LEVEL, LEVEL_HIGH);
  endtask : t_latch

  task automatic t_override();
    wr(ADDR_PRESET_FIRST, 8'h0f);
    chk("ports over", 8'h0f, port_active);
    wr(ADDR_POWER_LEVEL, 8'h00);
    chk("level over", 8'h00, port_high);
    rd_chk("first over", ADDR_PRESET_FIRST, 8'h0f);
  endtask : t_override

  task automatic t_hwreset();
    hw_reset_n <= 1'b0;
    repeat (10) @(posedge clock);
    chk("ports off", 8'h00, port_active);
    chk("auto off", 8'h00, {7'h00, auto_mode});
    hw_reset_n <= 1'b1;
    repeat (10) @(posedge clock);
    rd_chk("first cleared", ADDR_PRESET_FIRST, 8'h00);
    chk("ports still off", 8'h00, port_active);
  endtask : t_hwreset

  task automatic t_host();
    power_up(CLASS_OPEN);
    wr(ADDR_PRESET_FIRST, 8'ha5);
    wr(ADDR_PRESET_SECOND, 8'hff);
    wr(ADDR_POWER_LEVEL, 8'h05);
    chk("host ports", 8'ha5, port_active);
    chk("host level", 8'h05, port_high);
    rd_chk("unmapped", 8'h50, 8'h00);
  endtask : t_host

  initial begin
    arst_n      = 1'b0;
    hw_reset_n  = 1'b1;
    strap_class = 2'h0;
    errors      = 0;
    checks      = 0;
    t_strap(CLASS_OPEN, REG_CLEAR, REG_CLEAR, LEVEL_LOW, 1'b0, 8'h00);
    t_strap(2'h3, REG_CLEAR, REG_CLEAR, LEVEL_LOW, 1'b0, 8'h00);
    t_strap(CLASS_124K, REG_ALL_PORTS, REG_ALL_PORTS, LEVEL_LOW, 1'b1, 8'h00);
    t_strap(CLASS_62K, REG_ALL_PORTS, REG_ALL_PORTS, LEVEL_HIGH, 1'b1, 8'hff);
    t_latch();
    t_override();
    t_hwreset();
    t_host();
    complete_run();
  end

  // about 16k cycles expected, so this only trips on a hang
  initial begin
    repeat (80000) @(posedge clock);
    errors++;
    complete_run();
  end
endmodule : tb_strap_autonomous_config_loader
`default_nettype wire
